// file: core/ucounter_regs.vh
// Register indices, field positions, mode codes and reset values for the counter input block
// Notes on behaviour
// - I/O setup with selector 3 uses bit b3 to pick the high-frequency pin role, 0 counter input, 1 general input.
// - I/O setup with selector 3 uses bit b2 to pick the low-frequency pin role, 0 counter input, 1 general input.
// - Counter setup with b3=0 and b2=0 selects frequency measurement on the high-frequency pin.
// - Counter setup with b3=0 and b2=1 selects frequency measurement on the low-frequency pin.
// - Counter setup with b3=1 and b2=0 selects period measurement on the low-frequency pin.
// - Software sets the count time first, and the counter control write then starts the count in either mode.
// - The count-done flag is set when a frequency or period count finishes.
// - In general-input role the high-frequency pin level reads as bit b0 of internal register 0EH.
// - In general-input role the low-frequency pin level reads as bit b1 of internal register 0EH.
// - In clock stop mode both counter pins are input-disabled and pulled down.
// - Reset selects counter input role for both pins and high-frequency frequency measurement.
// - A sense flip-flop records a power failure during backup mode and reads as b2 of the test bits.
// - The voltage-sense pin level reads as b3 of the test bits.
// - The voltage-sense pin stays enabled in clock stop mode and during reset.
// - Clock stop is entered by standby-allow set, standby pin low and the clock-halt write; pin high leaves it.
`ifndef UCOUNTER_REGS_VH
`define UCOUNTER_REGS_VH

// Register indices; the bus address is the index itself
`define IDX_IO_SETUP      8'h00
`define IDX_CNT_SETUP     8'h01
`define IDX_CNT_CONTROL   8'h02
`define IDX_COUNT_TIME    8'h03
`define IDX_TEST_BITS     8'h04
`define IDX_STATUS        8'h05
`define IDX_MASK          8'h06
`define IDX_RESULT        8'h07
`define IDX_STANDBY_ALLOW 8'h08
`define IDX_CLOCK_HALT    8'h09
`define IDX_INTERNAL_IN   8'h0E

// Field positions
`define SEL_LSB       4
`define SEL_MSB       7
`define SETUP_SEL_PIN 4'h3
`define B0            0
`define B1            1
`define B2            2
`define B3            3

// Counter modes {b3,b2}
`define MODE_FREQ_HF  2'h0
`define MODE_FREQ_LF  2'h1
`define MODE_PER_LF   2'h2

// Status bits
`define ST_COUNT_DONE 0
`define ST_SENSE      1

// Reset values
`define RST_TIME      16'h0064
`define RST_MASK      2'h0

`endif

// file: core/universal_counter_input_select.v
// Universal counter input selection, counting, clock stop and voltage sense logic
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "ucounter_regs.vh"

module universal_counter_input_select (
   // Clock and reset
   input  wire        clk_i,
   input  wire        reset_i,
   // Register port
   input  wire [7:0]  addr_i,
   input  wire [15:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [15:0] rdata_o,
   // Pins
   input  wire        high_freq_counter_input_i,
   input  wire        low_freq_counter_input_i,
   input  wire        voltage_sense_input_i,
   input  wire        standby_n_i,
   output wire        hf_pulldown_o,
   output wire        lf_pulldown_o,
   output wire        clock_stopped_o,
   // Interrupt
   output wire        irq_o
);

   // Engine states
   localparam [1:0] IDLE   = 2'd0;
   localparam [1:0] ARMING = 2'd1;
   localparam [1:0] RUN    = 2'd2;

   // Rising edge of a sampled pin
   function edge_up;
      input cur;
      input prev;
      begin
         edge_up = cur & ~prev;
      end
   endfunction

   // Write strobe aimed at one register index; every register shares this decode
   function reg_hit;
      input       strobe;
      input [7:0] index;
      input [7:0] want;
      begin
         reg_hit = strobe & (index == want);
      end
   endfunction

   // One step up of a 16-bit count; both engines count up
   function [15:0] step_up;
      input [15:0] value;
      begin
         step_up = value + 16'h0001;
      end
   endfunction

   // One step down of the gate, which counts towards its last clock or edge
   function [15:0] step_down;
      input [15:0] value;
      begin
         step_down = value - 16'h0001;
      end
   endfunction

   // Counter pin routed to the engine; code 3 is not a legal mode and falls to the low pin
   function pin_for_mode;
      input [1:0] mode;
      input       hf_level;
      input       lf_level;
      begin
         if (mode == `MODE_FREQ_HF) begin
            pin_for_mode = hf_level;
         end else begin
            pin_for_mode = lf_level;
         end
      end
   endfunction

   // Pin roles and counter configuration
   reg        hf_gp_q;
   reg        lf_gp_q;
   reg [1:0]  mode_q;
   reg [15:0] time_q;
   // Measurement engine
   reg [15:0] gate_q;
   reg [15:0] cnt_q;
   reg [15:0] result_q;
   reg [1:0]  state_q;
   reg        prev_q;
   // Events, mask, standby and sense
   reg [1:0]  status_q;
   reg [1:0]  status_d;
   reg [1:0]  mask_q;
   reg        allow_q;
   reg        stop_q;
   reg        sense_q;
   // Decoded strobes and gated pin levels
   wire [7:0] idx;
   wire       hf_in;
   wire       lf_in;
   wire       sel_in;
   wire       rise;
   wire       start;
   reg        done_evt;
   wire       fail_evt;
   wire [15:0] time_eff;

   // Decoded write strobes, one per register
   wire       wr_io_setup;
   wire       wr_cnt_setup;
   wire       wr_time;
   wire       wr_status;
   wire       wr_mask;
   wire       wr_allow;
   wire       wr_halt;
   wire       wr_test;

   // Role-split pin levels and engine helpers
   wire       hf_count;
   wire       lf_count;
   wire       hf_level;
   wire       lf_level;
   wire       gate_last;
   wire       mode_period;
   wire       halt_ok;

   assign idx = addr_i;

   // Register writes; a write to an unmapped index hits none of these and is dropped
   assign wr_io_setup  = reg_hit(wr_i, idx, `IDX_IO_SETUP);
   assign wr_cnt_setup = reg_hit(wr_i, idx, `IDX_CNT_SETUP);
   assign wr_time      = reg_hit(wr_i, idx, `IDX_COUNT_TIME);
   assign wr_status    = reg_hit(wr_i, idx, `IDX_STATUS);
   assign wr_mask      = reg_hit(wr_i, idx, `IDX_MASK);
   assign wr_allow     = reg_hit(wr_i, idx, `IDX_STANDBY_ALLOW);
   assign wr_halt      = reg_hit(wr_i, idx, `IDX_CLOCK_HALT);
   assign wr_test      = reg_hit(wr_i, idx, `IDX_TEST_BITS);

   // Counter pins are cut off while the clock is stopped
   assign hf_in         = high_freq_counter_input_i & ~stop_q;
   assign lf_in         = low_freq_counter_input_i & ~stop_q;
   assign hf_pulldown_o = stop_q;
   assign lf_pulldown_o = stop_q;
   assign clock_stopped_o = stop_q;

   // Pin levels after the stop gate, split by role
   assign hf_count = hf_in & ~hf_gp_q;
   assign lf_count = lf_in & ~lf_gp_q;
   assign hf_level = hf_in & hf_gp_q;
   assign lf_level = lf_in & lf_gp_q;

   // Pin feeding the counter; a general-input role starves it
   assign sel_in      = pin_for_mode(mode_q, hf_count, lf_count);
   assign rise        = edge_up(sel_in, prev_q);
   assign start       = reg_hit(wr_i, idx, `IDX_CNT_CONTROL);
   assign mode_period = (mode_q == `MODE_PER_LF);
   assign gate_last   = (gate_q == 16'h0001);
   // A zero count time would wrap round to a full 65536-step gate, so it runs as one
   assign time_eff = (time_q == 16'h0000) ? 16'h0001 : time_q;

   // Halt is honoured only with standby allowed and the standby pin already low
   assign halt_ok = wr_halt & allow_q & ~standby_n_i;

   // Power failure seen on the sense pin while backed up
   assign fail_evt = stop_q & ~voltage_sense_input_i;

   // Pin role selection over the I/O setup word
   // Other selector values set up other pins and are ignored here
   always @(posedge clk_i) begin
      if (reset_i) begin
         hf_gp_q <= 1'b0;
         lf_gp_q <= 1'b0;
      end else if (wr_io_setup && wdata_i[`SEL_MSB:`SEL_LSB] == `SETUP_SEL_PIN) begin
         hf_gp_q <= wdata_i[`B3];
         lf_gp_q <= wdata_i[`B2];
      end
   end

   // Mode, count time, mask and standby-allow registers
   // Mode code 3 is not a legal setting; it runs as low-pin frequency
   always @(posedge clk_i) begin
      if (reset_i) begin
         mode_q  <= `MODE_FREQ_HF;
         time_q  <= `RST_TIME;
         mask_q  <= `RST_MASK;
         allow_q <= 1'b0;
      end else if (wr_i) begin
         if (wr_cnt_setup) begin
            mode_q <= {wdata_i[`B3], wdata_i[`B2]};
         end
         if (wr_time) begin
            time_q <= wdata_i;
         end
         if (wr_mask) begin
            mask_q <= wdata_i[1:0];
         end
         if (wr_allow) begin
            allow_q <= wdata_i[`B0];
         end
      end
   end

   // Clock stop entry and exit
   // Leaving needs only the pin, so a wake-up is never lost to the allow flag
   always @(posedge clk_i) begin
      if (reset_i) begin
         stop_q <= 1'b0;
      end else if (stop_q) begin
         stop_q <= ~standby_n_i;
      end else if (halt_ok) begin
         stop_q <= 1'b1;
      end
   end

   // Measurement engine: frequency counts edges over the gate, period counts clocks over edges
   // Only one count runs at a time; a new start restarts it, which keeps software simple
   // at the cost of losing a count that was still under way
   always @(posedge clk_i) begin
      done_evt <= 1'b0;
      if (reset_i) begin
         state_q  <= IDLE;
         gate_q   <= 16'h0000;
         cnt_q    <= 16'h0000;
         result_q <= 16'h0000;
         prev_q   <= 1'b0;
         done_evt <= 1'b0;
      end else begin
         prev_q <= sel_in;
         if (start) begin
            // Count begins on the control write with the time already chosen
            gate_q  <= time_eff;
            cnt_q   <= 16'h0000;
            state_q <= mode_period ? ARMING : RUN;
         end else if (stop_q) begin
            state_q <= IDLE; // A halted clock abandons any count
         end else begin
            case (state_q)
               IDLE: begin
                  state_q <= IDLE;
               end
               ARMING: begin
                  if (rise) begin
                     state_q <= RUN;
                  end
               end
               RUN: begin
                  if (mode_period) begin
                     // Period: clocks from the arming edge to the last of T further edges
                     cnt_q <= step_up(cnt_q);
                     if (rise) begin
                        if (gate_last) begin
                           result_q <= step_up(cnt_q);
                           done_evt <= 1'b1;
                           state_q  <= IDLE;
                        end else begin
                           gate_q <= step_down(gate_q);
                        end
                     end
                  end else begin
                     // Frequency: edges counted over T clocks, the last clock included
                     if (rise) begin
                        cnt_q <= step_up(cnt_q);
                     end
                     if (gate_last) begin
                        result_q <= rise ? step_up(cnt_q) : cnt_q;
                        done_evt <= 1'b1;
                        state_q  <= IDLE;
                     end else begin
                        gate_q <= step_down(gate_q);
                     end
                  end
               end
               default: begin
                  state_q <= IDLE;
               end
            endcase
         end
      end
   end

   // Sticky status: events set, a written one clears, set wins over clear
   // A done landing on a start edge still reports; the start only clears older news
   always @* begin
      status_d = status_q;
      if (wr_status) begin
         status_d = status_d & ~wdata_i[1:0];
      end
      if (start) begin
         status_d[`ST_COUNT_DONE] = 1'b0;
      end
      if (done_evt) begin
         status_d[`ST_COUNT_DONE] = 1'b1;
      end
      if (fail_evt) begin
         status_d[`ST_SENSE] = 1'b1;
      end
   end

   // Status register
   always @(posedge clk_i) begin
      if (reset_i) begin
         status_q <= 2'h0;
      end else begin
         status_q <= status_d;
      end
   end

   // Level interrupt, high while any unmasked event is pending
   assign irq_o = |(status_q & mask_q);

   // Sense flip-flop: set at power-up and by a failure, cleared by writing b2 of the test bits
   // Power-up counts as a failure, so a cold start is always reported once
   always @(posedge clk_i) begin
      if (reset_i) begin
         sense_q <= 1'b1;
      end else if (fail_evt) begin
         sense_q <= 1'b1;
      end else if (wr_test && wdata_i[`B2]) begin
         sense_q <= 1'b0;
      end
   end

   // Read data, valid in the cycle after the read strobe only
   // Unmapped and write-only indices read as zero
   always @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (idx)
            `IDX_IO_SETUP:      rdata_o <= {12'h000, hf_gp_q, lf_gp_q, 2'h0};
            `IDX_CNT_SETUP:     rdata_o <= {12'h000, mode_q, 2'h0};
            `IDX_COUNT_TIME:    rdata_o <= time_q;
            `IDX_TEST_BITS:     rdata_o <= {12'h000, voltage_sense_input_i, sense_q, 2'h0};
            `IDX_STATUS:        rdata_o <= {14'h0000, status_q};
            `IDX_MASK:          rdata_o <= {14'h0000, mask_q};
            `IDX_RESULT:        rdata_o <= result_q;
            `IDX_STANDBY_ALLOW: rdata_o <= {15'h0000, allow_q};
            `IDX_CLOCK_HALT:    rdata_o <= {15'h0000, stop_q};
            `IDX_INTERNAL_IN:   rdata_o <= {14'h0000, lf_level, hf_level};
            default:            rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

endmodule // universal_counter_input_select

// file: test/universal_counter_input_select_props.sv
// Port checks for the counter input block
`timescale 1ns/1ns
module ucis_props (
   // Clock, reset and bus
   input wire        clk_i,
   input wire        reset_i,
   input wire [7:0]  addr_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [15:0] rdata_o,
   // Pins
   input wire        voltage_sense_input_i,
   input wire        standby_n_i,
   input wire        hf_pulldown_o,
   input wire        lf_pulldown_o,
   input wire        clock_stopped_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Read data stands one cycle only
   property p_rd; !rd_i |=> rdata_o == 16'h0000; endproperty
   a_rd: assert property (p_rd) else $error("stray read data");
   // Pull-downs follow clock stop
   property p_pd; hf_pulldown_o == clock_stopped_o && lf_pulldown_o == clock_stopped_o; endproperty
   a_pd: assert property (p_pd) else $error("pull-down mismatch");
   // Stop only from a halt write with standby low
   property p_in; $rose(clock_stopped_o) |-> $past(wr_i) && $past(addr_i) == 8'h09 && !$past(standby_n_i); endproperty
   a_in: assert property (p_in) else $error("bad stop entry");
   property p_hold; clock_stopped_o && !standby_n_i |=> clock_stopped_o; endproperty
   a_hold: assert property (p_hold) else $error("stop lost");
   property p_out; clock_stopped_o && standby_n_i |=> !clock_stopped_o; endproperty
   a_out: assert property (p_out) else $error("stop not left");
   // Counter pins read low while stopped, input disabled
   property p_gp; rd_i && addr_i == 8'h0E && clock_stopped_o |=> rdata_o[1:0] == 2'h0; endproperty
   a_gp: assert property (p_gp) else $error("pin seen in stop");
   // Sense pin level reads back, also in stop
   property p_sns; rd_i && addr_i == 8'h04 |=> rdata_o[3] == $past(voltage_sense_input_i); endproperty
   a_sns: assert property (p_sns) else $error("sense level wrong");
   property p_rst; $fell(reset_i) |-> !clock_stopped_o && rdata_o == 16'h0000; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
endmodule // ucis_props

bind universal_counter_input_select ucis_props u_props (.*);

// file: test/test_universal_counter_input_select.sv
// Directed register-level bench for the counter input block
`timescale 1ns/1ns
module test_universal_counter_input_select;
   reg         clk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg  [7:0]  addr_i = 8'h00;
   reg  [15:0] wdata_i = 16'h0000;
   reg         wr_i = 1'b0;
   reg         rd_i = 1'b0;
   reg         hf = 1'b0;
   reg         lf = 1'b0;
   reg         voltage_sense_input = 1'b1;
   reg         sb_n = 1'b1;
   reg  [15:0] last;
   wire [15:0] rdata_o;
   wire        hf_pd, lf_pd, stopped, irq;
   integer     num_errors = 0;
   integer     cmp_count = 0;
   integer     i, m;
   // 10 MHz clock
   always #50 clk_i = ~clk_i;
   universal_counter_input_select dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .high_freq_counter_input_i(hf), .low_freq_counter_input_i(lf), .voltage_sense_input_i(voltage_sense_input),
      .standby_n_i(sb_n), .hf_pulldown_o(hf_pd), .lf_pulldown_o(lf_pd), .clock_stopped_o(stopped), .irq_o(irq));
   task chk(input [15:0] got, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk1(input got, input exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   // One-cycle bus write
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge clk_i);
         wr_i <= 1'b1;
         addr_i <= a;
         wdata_i <= d;
         @(posedge clk_i);
         wr_i <= 1'b0;
      end
   endtask
   // Read data is looked at only in the cycle after the strobe
   task rd(input [7:0] a, input [15:0] exp);
      begin
         @(posedge clk_i);
         rd_i <= 1'b1;
         addr_i <= a;
         @(posedge clk_i);
         rd_i <= 1'b0;
         @(negedge clk_i);
         last = rdata_o;
         chk(last, exp);
         @(posedge clk_i);
      end
   endtask
   // Pulse trains on both pins, kept short of the gate end in the frequency modes
   task pulses(input integer nh, input integer nl);
      for (i = 0; i < 5; i = i + 1) begin
         repeat (2) @(posedge clk_i);
         hf <= (i < nh);
         lf <= (i < nl);
         repeat (2) @(posedge clk_i);
         hf <= 1'b0;
         lf <= 1'b0;
      end
   endtask
   task report_and_stop;
      begin
         $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // Watchdog well beyond the few hundred cycles the tests take
   initial begin
      repeat (5000) @(posedge clk_i);
      num_errors = num_errors + 1;
      report_and_stop;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(8'h00, 16'h0000);
      rd(8'h01, 16'h0000);
      rd(8'h03, 16'h0064);
      rd(8'h04, 16'h000C);
      rd(8'h0A, 16'h0000);
      $display("Test reset done");
      wr(8'h00, 16'h003C);
      hf <= 1'b1;
      rd(8'h0E, 16'h0001);
      hf <= 1'b0;
      lf <= 1'b1;
      rd(8'h0E, 16'h0002);
      lf <= 1'b0;
      wr(8'h00, 16'h0020);
      rd(8'h00, 16'h000C);
      wr(8'h00, 16'h0030);
      $display("Test roles done");
      wr(8'h06, 16'h0001);
      wr(8'h03, 16'h0028);
      // Modes: HF freq, LF freq, LF period; the other pin also pulses in the two frequency modes
      for (m = 0; m < 3; m = m + 1) begin
         if (m == 2)
            wr(8'h03, 16'h0002);
         wr(8'h01, {12'h000, m[1:0], 2'h0});
         wr(8'h02, 16'h0000);
         rd(8'h05, 16'h0000);
         if (m == 2)
            pulses(0, 4);
         else
            pulses(3, 5);
         for (i = 0; i < 100 && irq !== 1'b1; i = i + 1)
            @(posedge clk_i);
         rd(8'h05, 16'h0001);
         rd(8'h07, (m == 0) ? 16'h0003 : (m == 1) ? 16'h0005 : 16'h0008);
      end
      chk1(last >= 16'h0007 && last <= 16'h0009, 1'b1);
      @(negedge clk_i) chk1(irq, 1'b1);
      wr(8'h06, 16'h0000);
      @(negedge clk_i) chk1(irq, 1'b0);
      wr(8'h06, 16'h0001);
      @(negedge clk_i) chk1(irq, 1'b1);
      wr(8'h05, 16'h0001);
      @(negedge clk_i) chk1(irq, 1'b0);
      $display("Test count done");
      wr(8'h00, 16'h003C);
      hf <= 1'b1;
      lf <= 1'b1;
      wr(8'h04, 16'h0004);
      rd(8'h04, 16'h0008);
      sb_n <= 1'b0;
      wr(8'h09, 16'h0000);
      rd(8'h09, 16'h0000);
      wr(8'h08, 16'h0001);
      wr(8'h09, 16'h0000);
      rd(8'h09, 16'h0001);
      @(negedge clk_i) chk1(hf_pd & lf_pd, 1'b1);
      rd(8'h0E, 16'h0000);
      voltage_sense_input <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(8'h04, 16'h0004);
      voltage_sense_input <= 1'b1;
      sb_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i) chk1(stopped, 1'b0);
      rd(8'h05, 16'h0002);
      rd(8'h0E, 16'h0003);
      $display("Test stop done");
      report_and_stop;
   end
endmodule // test_universal_counter_input_select
